// ===== design/mdc_pkg.sv
/*
  Shared constants and types for the multiply/divide coprocessor:
  mode word layout, operation and output codes, reset values, divider timing.
  Assumes a single clock domain driven by the issuing 16-bit core.
*/
package mdc_pkg;

  // Mode word layout
  localparam int MODE_W = 7;
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam int OUT_LSB = 4;
  localparam int OUT_W = 3;
  localparam logic [6:0] MODE_RESET = 7'h00;

  // Output mode codes, mode bits 6..4
  localparam logic [2:0] OUT_R0_LO = 3'h0;
  localparam logic [2:0] OUT_R0_HI = 3'h1;
  localparam logic [2:0] OUT_R1_LO = 3'h2;
  localparam logic [2:0] OUT_R1_HI = 3'h3;

  // Operation codes, mode bits 3..0
  localparam logic [3:0] OP_CLEAR = 4'h0;
  localparam logic [3:0] OP_LOAD_AUGEND = 4'h1;
  localparam logic [3:0] OP_LOAD_R0 = 4'h2;
  localparam logic [3:0] OP_READ = 4'h3;
  localparam logic [3:0] OP_MUL_U = 4'h4;
  localparam logic [3:0] OP_MUL_S = 4'h5;
  localparam logic [3:0] OP_MAC_U = 4'h6;
  localparam logic [3:0] OP_MAC_S = 4'h7;
  localparam logic [3:0] OP_DIV_U = 4'h8;
  localparam logic [3:0] OP_DIV_S = 4'h9;
  localparam logic [3:0] OP_LOAD_R1 = 4'ha;

  // Reset values and flag layout (C V Z N)
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int FLAG_V = 2;

  // Divider: two quotient bits per cycle, sixteen iteration cycles
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam int DIV_MIN_CYC = 17;
  localparam int DIV_MAX_CYC = 20;

  // Controller states
  typedef enum logic [1:0] {
    MDC_IDLE = 2'b01,
    MDC_DIV = 2'b10
  } mdc_ctl_state_t;

  // Divider states
  typedef enum logic [2:0] {
    MDC_DV_IDLE = 3'b001,
    MDC_DV_RUN = 3'b010,
    MDC_DV_FIX = 3'b100
  } mdc_div_state_t;

endpackage : mdc_pkg

// ===== design/mdc_mul_mac.sv
/*
  Single-cycle 16x16 multiplier with optional 32-bit accumulate and
  accumulate overflow detection. Purely combinational.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module mdc_mul_mac (
  // Operands
  input wire logic [15:0] mul_a,
  input wire logic [15:0] mul_b,
  input wire logic [31:0] acc,
  // Controls
  input wire logic is_signed,
  input wire logic accumulate,
  // Results
  output logic [31:0] result,
  output logic overflow
);
  import mdc_pkg::*;

  logic signed [31:0] prod_s;
  logic [31:0] prod_u;
  logic [31:0] prod;
  logic [32:0] sum;

  // Product, sum and overflow
  always_comb begin
    prod_s = $signed(mul_a) * $signed(mul_b);
    prod_u = mul_a * mul_b;
    prod = is_signed ? prod_s : prod_u;
    sum = {1'b0, acc} + {1'b0, prod};
    result = accumulate ? sum[31:0] : prod;
    if (!accumulate) begin
      overflow = 1'b0;
    end else if (is_signed) begin
      overflow = (acc[31] == prod[31]) && (sum[31] != acc[31]);
    end else begin
      overflow = sum[32]; // Carry out of the accumulator
    end
  end

endmodule : mdc_mul_mac

// ===== design/mdc_divider.sv
/*
  Iterative 32/32 divider, signed or unsigned, radix-4 restoring.
  One load cycle, sixteen iteration cycles, one sign-fix cycle.
  Assumes start only while idle; zero divisor is not handled.
*/
`timescale 1ns/1ps
module mdc_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request
  input wire logic start,
  input wire logic is_signed,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  // Answer
  output logic [31:0] quotient,
  output logic [31:0] remainder,
  output logic done
);
  import mdc_pkg::*;

  typedef struct packed {
    mdc_div_state_t state;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
    logic [3:0] cnt;
    logic neg_q;
    logic neg_r;
    logic done;
  } mdc_div_st_t;

  mdc_div_st_t st_reg;
  mdc_div_st_t st_next;
  logic [63:0] step1;
  logic [63:0] step2;

  // Magnitude of an operand
  function automatic logic [31:0] abs32(input logic [31:0] v, input logic sgn);
    abs32 = (sgn && v[31]) ? -v : v;
  endfunction : abs32

  // One restoring step on {remainder, quotient}
  function automatic logic [63:0] div_step(input logic [63:0] rq, input logic [31:0] d);
    logic [32:0] t;
    logic [32:0] diff;
    t = {rq[63:32], rq[31]};
    diff = t - {1'b0, d};
    if (!diff[32]) begin
      div_step = {diff[31:0], rq[30:0], 1'b1};
    end else begin
      div_step = {t[31:0], rq[30:0], 1'b0};
    end
  endfunction : div_step

  // Next state: load, iterate two bits per cycle, fix signs
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    step1 = div_step({st_reg.rem, st_reg.quo}, st_reg.den);
    step2 = div_step(step1, st_reg.den);
    case (st_reg.state)
      MDC_DV_IDLE: begin
        if (start) begin
          st_next.rem = RESULT_RESET;
          st_next.quo = abs32(dividend, is_signed);
          st_next.den = abs32(divisor, is_signed);
          st_next.neg_q = is_signed && (dividend[31] ^ divisor[31]);
          st_next.neg_r = is_signed && dividend[31];
          st_next.cnt = 4'h0;
          st_next.state = MDC_DV_RUN;
        end
      end
      MDC_DV_RUN: begin
        st_next.rem = step2[63:32];
        st_next.quo = step2[31:0];
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == DIV_LAST) begin
          st_next.state = MDC_DV_FIX;
        end
      end
      MDC_DV_FIX: begin
        if (st_reg.neg_q) st_next.quo = -st_reg.quo;
        if (st_reg.neg_r) st_next.rem = -st_reg.rem;
        st_next.done = 1'b1;
        st_next.state = MDC_DV_IDLE;
      end
      default: st_next.state = MDC_DV_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{MDC_DV_IDLE, RESULT_RESET, RESULT_RESET, RESULT_RESET, 4'h0, 1'b0, 1'b0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign quotient = st_reg.quo;
  assign remainder = st_reg.rem;
  assign done = st_reg.done;

endmodule : mdc_divider

// ===== design/multiply_divide_coprocessor.sv
/*
  Multiply, multiply-accumulate and divide coprocessor for a 16-bit core.
  Holds the 7-bit mode word and two 32-bit result registers, and returns the
  selected 16-bit half after each operate request.
  Assumes the core drives the request ports synchronously on clk and does not
  issue requests while busy is high.
*/
//
// Behaviour
// - Multiply two 16-bit operands, signed or unsigned, to 32 bits in one cycle.
// - Multiply-accumulate into a 32-bit result in one cycle, flagging overflow.
// - Divide 32 by 32 bits, signed or unsigned, in 17 to 20 cycles.
// - Mode write takes a 7-bit word from the source operand; destination unused.
// - Only one 16-bit half of a result register is presented per read.
// - Output field picks low/high half of register zero or one; 4-7 reserved.
// - Operation 0x0 clears both result registers.
// - Operation 0x1 loads a 16-bit augend into the low half of register zero.
// - Operation 0x2 loads register zero, 0xa loads register one, 32 bits.
// - Operation 0x3 only presents results, with no change to them.
// - Operations 0x4-0x9 are multiply, MAC and divide; 0xb-0xf are reserved.
// - Division leaves quotient in register zero and remainder in register one.
`timescale 1ns/1ps
module multiply_divide_coprocessor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Mode write instruction
  input wire logic mode_wr_valid,
  input wire logic [mdc_pkg::MODE_W-1:0] mode_wr_data,
  // Operate instruction
  input wire logic op_valid,
  input wire logic [15:0] op_high,
  input wire logic [15:0] op_low,
  // Result to the core
  output logic [15:0] result_half,
  output logic result_valid,
  output logic busy,
  output logic [3:0] flags
);
  import mdc_pkg::*;

  typedef struct packed {
    mdc_ctl_state_t state;
    logic [6:0] mode;
    logic [31:0] result_register_zero;
    logic [31:0] result_register_one;
    logic [15:0] result_half;
    logic result_valid;
    logic busy;
    logic [3:0] flags;
  } mdc_ctl_st_t;

  mdc_ctl_st_t st_reg;
  mdc_ctl_st_t st_next;
  logic [3:0] op_code;
  logic [2:0] out_code;
  logic div_start;
  logic [31:0] mac_result;
  logic mac_ovf;
  logic [31:0] div_quo;
  logic [31:0] div_rem;
  logic div_done;

  assign op_code = st_reg.mode[OP_LSB +: OP_W];
  assign out_code = st_reg.mode[OUT_LSB +: OUT_W];

  // Half of a result register chosen by the mode word, zero if reserved
  function automatic logic [15:0] sel_half(input logic [6:0] mode, input logic [31:0] r0,
                                           input logic [31:0] r1);
    logic [3:0] op;
    op = mode[OP_LSB +: OP_W];
    sel_half = HALF_RESET;
    if (op <= OP_LOAD_R1) begin
      case (mode[OUT_LSB +: OUT_W])
        OUT_R0_LO: sel_half = r0[15:0];
        OUT_R0_HI: sel_half = r0[31:16];
        OUT_R1_LO: sel_half = r1[15:0];
        OUT_R1_HI: sel_half = r1[31:16];
        default: sel_half = HALF_RESET;
      endcase
    end
  endfunction : sel_half

  // Multiplier and accumulator, rd operand times rs operand
  mdc_mul_mac u_mul_mac (
    .mul_a(op_high),
    .mul_b(op_low),
    .acc(st_reg.result_register_zero),
    .is_signed(op_code[0]),
    .accumulate(op_code == OP_MAC_U || op_code == OP_MAC_S),
    .result(mac_result),
    .overflow(mac_ovf)
  );

  // Divider, dividend held in register zero
  mdc_divider u_divider (
    .clk(clk),
    .rst_b(rst_b),
    .start(div_start),
    .is_signed(op_code[0]),
    .dividend(st_reg.result_register_zero),
    .divisor({op_high, op_low}),
    .quotient(div_quo),
    .remainder(div_rem),
    .done(div_done)
  );

  // Request decode and result update
  always_comb begin
    st_next = st_reg;
    st_next.result_valid = 1'b0;
    div_start = 1'b0;
    case (st_reg.state)
      MDC_IDLE: begin
        if (mode_wr_valid) begin
          st_next.mode = mode_wr_data;
        end else if (op_valid) begin
          st_next.result_valid = 1'b1;
          st_next.flags = FLAGS_RESET;
          case (op_code)
            OP_CLEAR: begin
              st_next.result_register_zero = RESULT_RESET;
              st_next.result_register_one = RESULT_RESET;
            end
            OP_LOAD_AUGEND: st_next.result_register_zero[15:0] = op_low;
            OP_LOAD_R0: st_next.result_register_zero = {op_high, op_low};
            OP_LOAD_R1: st_next.result_register_one = {op_high, op_low};
            OP_READ: st_next.result_valid = 1'b1;
            OP_MUL_U, OP_MUL_S, OP_MAC_U, OP_MAC_S: begin
              st_next.result_register_zero = mac_result;
              st_next.flags[FLAG_V] = mac_ovf;
            end
            OP_DIV_U, OP_DIV_S: begin
              div_start = 1'b1;
              st_next.result_valid = 1'b0;
              st_next.busy = 1'b1;
              st_next.state = MDC_DIV;
            end
            default: st_next.result_valid = 1'b1;
          endcase
        end
      end
      MDC_DIV: begin
        if (div_done) begin
          st_next.result_register_zero = div_quo;
          st_next.result_register_one = div_rem;
          st_next.result_valid = 1'b1;
          st_next.busy = 1'b0;
          st_next.state = MDC_IDLE;
        end
      end
      default: st_next.state = MDC_IDLE;
    endcase
    st_next.result_half = sel_half(st_next.mode, st_next.result_register_zero,
                                   st_next.result_register_one);
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{MDC_IDLE, MODE_RESET, RESULT_RESET, RESULT_RESET, HALF_RESET, 1'b0, 1'b0,
                  FLAGS_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign result_half = st_reg.result_half;
  assign result_valid = st_reg.result_valid;
  assign busy = st_reg.busy;
  assign flags = st_reg.flags;

  // Helper terms for the checks, worked out apart from the datapath
  logic idle_op;
  logic [31:0] r0;
  logic [31:0] r1;
  logic [31:0] uprod;
  logic [31:0] sprod;
  logic [32:0] usum;
  logic [32:0] ssum;
  logic [15:0] exp_half;
  assign idle_op = op_valid && !mode_wr_valid && st_reg.state == MDC_IDLE;
  assign r0 = st_reg.result_register_zero;
  assign r1 = st_reg.result_register_one;

  // Reference products and sums, zero- or sign-extended
  assign uprod = {16'h0000, op_high} * {16'h0000, op_low};
  assign sprod = {{16{op_high[15]}}, op_high} * {{16{op_low[15]}}, op_low};
  assign usum = {1'b0, r0} + {1'b0, uprod};
  assign ssum = {r0[31], r0} + {sprod[31], sprod};

  // Reference output half, zero for reserved codes
  always_comb begin
    case (out_code)
      OUT_R0_LO: exp_half = r0[15:0];
      OUT_R0_HI: exp_half = r0[31:16];
      OUT_R1_LO: exp_half = r1[15:0];
      OUT_R1_HI: exp_half = r1[31:16];
      default: exp_half = HALF_RESET;
    endcase
    if (op_code > OP_LOAD_R1) begin
      exp_half = HALF_RESET;
    end
  end

  default clocking mdc_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Mode word taken while idle
  mode_write_a: assert property (mode_wr_valid && !busy |=>
    st_reg.mode == $past(mode_wr_data))
    else $error("mode word not stored");

  // Mode word held while dividing
  mode_hold_a: assert property (busy |=> $stable(st_reg.mode))
    else $error("mode word changed while busy");

  // Unsigned product in one cycle
  mul_result_a: assert property (idle_op && op_code == OP_MUL_U |=>
    result_valid && r0 == $past(uprod))
    else $error("unsigned product wrong or late");

  // Signed product in one cycle
  mul_signed_a: assert property (idle_op && op_code == OP_MUL_S |=>
    result_valid && r0 == $past(sprod))
    else $error("signed product wrong or late");

  // Unsigned accumulate, carry out as overflow
  mac_sum_a: assert property (idle_op && op_code == OP_MAC_U |=>
    {flags[FLAG_V], r0} == $past(usum))
    else $error("accumulate result wrong");

  // Signed accumulate, two's complement overflow
  mac_signed_a: assert property (idle_op && op_code == OP_MAC_S |=>
    r0 == $past(ssum[31:0]) && flags[FLAG_V] == ($past(ssum[32]) != $past(ssum[31])))
    else $error("signed accumulate wrong");

  // Flags cleared by every other operation
  flag_clear_a: assert property (idle_op && op_code[3:1] != 3'h3 |=>
    flags == FLAGS_RESET)
    else $error("flags set outside accumulate");

  // One-cycle answer for non-divide operations
  op_answer_a: assert property (idle_op && op_code[3:1] != 3'h4 |=>
    result_valid && !busy)
    else $error("operation answer missing");

  // Division raises busy and holds the answer back
  div_start_a: assert property (idle_op && op_code[3:1] == 3'h4 |=>
    busy && !result_valid)
    else $error("division did not start");

  // Division answer within the allowed span
  div_latency_a: assert property (idle_op && op_code[3:1] == 3'h4 |=>
    busy ##[16:19] (result_valid && !busy))
    else $error("division not done in 17 to 20 cycles");

  // Results untouched while dividing
  busy_hold_a: assert property (busy && !div_done |=> $stable(r0) && $stable(r1))
    else $error("results changed while busy");

  // Quotient and remainder stored on completion
  div_regs_a: assert property (div_done |=>
    r0 == $past(div_quo) && r1 == $past(div_rem))
    else $error("quotient or remainder not stored");

  // Presented half follows the output field
  out_select_a: assert property (result_half == exp_half)
    else $error("presented half does not match mode");

  // Reserved output field presents zero
  out_reserved_a: assert property (out_code > OUT_R1_HI |->
    result_half == HALF_RESET)
    else $error("reserved output not zero");

  // Clear empties both registers
  clear_regs_a: assert property (idle_op && op_code == OP_CLEAR |=>
    r0 == 32'h0000_0000 && r1 == 32'h0000_0000)
    else $error("clear left data");

  // Augend load touches the low half only
  augend_load_a: assert property (idle_op && op_code == OP_LOAD_AUGEND |=>
    r0[15:0] == $past(op_low) && r0[31:16] == $past(r0[31:16]))
    else $error("augend load wrong");

  // Register zero load
  reg_zero_load_a: assert property (idle_op && op_code == OP_LOAD_R0 |=>
    r0 == {$past(op_high), $past(op_low)} && $stable(r1))
    else $error("register zero load wrong");

  // Register one load
  reg_load_a: assert property (idle_op && op_code == OP_LOAD_R1 |=>
    r1 == {$past(op_high), $past(op_low)} && $stable(r0))
    else $error("register one load wrong");

  // Read mode changes neither result register
  read_only_a: assert property (idle_op && op_code == OP_READ |=>
    $stable(r0) && $stable(r1))
    else $error("read mode changed results");

  // Reserved operation leaves both result registers unchanged
  reserved_zero_a: assert property (idle_op && op_code > OP_LOAD_R1 |=>
    $stable(r0) && $stable(r1) && result_half == 16'h0000)
    else $error("reserved operation had an effect");

  // Main scenarios
  mul_seen_c: cover property (idle_op && op_code == OP_MUL_S ##1 result_valid);
  mac_ovf_c: cover property (idle_op && op_code == OP_MAC_S ##1 flags[FLAG_V]);
  div_done_c: cover property (idle_op && op_code == OP_DIV_S ##[17:20] result_valid);
  div_refused_c: cover property (busy && op_valid);
  mode_collide_c: cover property (mode_wr_valid && op_valid && !busy);

endmodule : multiply_divide_coprocessor

// ===== testbench/mdc_core_model.sv
/*
  Core-side model: issues mode writes and operate requests, times answers.
  Assumes one clock shared with the coprocessor; requests change 1 ns after
  a rising edge.
*/
`timescale 1ns/1ps
module mdc_core_model (
  // Clock
  input wire logic clk,
  // Answer from the coprocessor
  input wire logic result_valid,
  // Requests to the coprocessor
  output logic mode_wr_valid,
  output logic [mdc_pkg::MODE_W-1:0] mode_wr_data,
  output logic op_valid,
  output logic [15:0] op_high,
  output logic [15:0] op_low
);
  import mdc_pkg::*;
  localparam int DRV = 1;
  int cyc = 0;
  int t0 = 0;
  // Idle lines at time zero
  initial begin
    mode_wr_valid = 1'b0;
    mode_wr_data = 7'h55;
    op_valid = 1'b0;
    op_high = 16'ha5a5;
    op_low = 16'h5a5a;
  end
  // Free-running count for latency
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // Seven-bit mode word, one-cycle strobe
  task automatic mode_write(input logic [6:0] m);
    @(posedge clk);
    #DRV;
    mode_wr_valid = 1'b1;
    mode_wr_data = m;
    @(posedge clk);
    #DRV;
    mode_wr_valid = 1'b0;
    mode_wr_data = ~m; // Released lines lose the old value
  endtask : mode_write
  // Both operands held to the taking edge; divisor never zero
  task automatic op_start(input logic [15:0] hi, input logic [15:0] lo);
    @(posedge clk);
    #DRV;
    t0 = cyc; // Count before the taking edge
    op_valid = 1'b1;
    op_high = hi;
    op_low = lo;
    @(posedge clk);
    #DRV;
    op_valid = 1'b0;
    op_high = ~hi;
    op_low = ~lo;
  endtask : op_start
  // Bounded wait for the completion pulse
  task automatic op_wait(output int lat);
    for (int i = 0; i < 40 && result_valid !== 1'b1; i++) begin
      @(posedge clk);
      #DRV;
    end
    lat = cyc - t0;
  endtask : op_wait
endmodule : mdc_core_model

// ===== testbench/multiply_divide_coprocessor_tb.sv
/*
  Self-checking bench: reset, then table of mode/operand rows, busy refusal,
  write/operate collision and mid-run reset.
  Assumes the core model drives every request port.
*/
`timescale 1ns/1ps
module multiply_divide_coprocessor_tb;
  import mdc_pkg::*;
  typedef struct {
    logic [6:0] mode;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] half;
    int lat;
    logic v;
  } mdc_row_t;
  localparam int NROW = 20;
  logic clk;
  logic rst_b;
  logic mode_wr_valid, op_valid, result_valid, busy;
  logic [6:0] mode_wr_data;
  logic [15:0] op_high, op_low, result_half;
  logic [3:0] flags;
  int n_errors = 0;
  int checks_done = 0;
  int lat;
  // Mode, operands, expected half, latency, overflow
  mdc_row_t rows [NROW] = '{
    '{7'h00, 16'h1234, 16'h5678, 16'h0000, 1, 1'b0},
    '{7'h02, 16'h0001, 16'h0002, 16'h0002, 1, 1'b0},
    '{7'h11, 16'h4444, 16'hbeef, 16'h0001, 1, 1'b0},
    '{7'h3a, 16'hdead, 16'hcafe, 16'hdead, 1, 1'b0},
    '{7'h23, 16'h5555, 16'h6666, 16'hcafe, 1, 1'b0},
    '{7'h04, 16'hffff, 16'hffff, 16'h0001, 1, 1'b0},
    '{7'h13, 16'h0000, 16'h0000, 16'hfffe, 1, 1'b0},
    '{7'h15, 16'hffff, 16'h0002, 16'hffff, 1, 1'b0},
    '{7'h16, 16'h0001, 16'h0002, 16'h0000, 1, 1'b1},
    '{7'h02, 16'h7fff, 16'hffff, 16'hffff, 1, 1'b0},
    '{7'h17, 16'h0001, 16'h0001, 16'h8000, 1, 1'b1},
    '{7'h02, 16'h0000, 16'h0064, 16'h0064, 1, 1'b0},
    '{7'h08, 16'h0000, 16'h0007, 16'h000e, 19, 1'b0},
    '{7'h23, 16'h0000, 16'h0000, 16'h0002, 1, 1'b0},
    '{7'h02, 16'hffff, 16'hff9c, 16'hff9c, 1, 1'b0},
    '{7'h19, 16'h0000, 16'h0007, 16'hffff, 19, 1'b0},
    '{7'h0b, 16'h1111, 16'h2222, 16'h0000, 1, 1'b0},
    '{7'h03, 16'h0000, 16'h0000, 16'hfff2, 1, 1'b0},
    '{7'h43, 16'h0000, 16'h0000, 16'h0000, 1, 1'b0},
    '{7'h33, 16'h0000, 16'h0000, 16'hffff, 1, 1'b0}
  };
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  multiply_divide_coprocessor DUT (
    .clk(clk), .rst_b(rst_b), .mode_wr_valid(mode_wr_valid),
    .mode_wr_data(mode_wr_data), .op_valid(op_valid), .op_high(op_high),
    .op_low(op_low), .result_half(result_half), .result_valid(result_valid),
    .busy(busy), .flags(flags)
  );
  mdc_core_model core (
    .clk(clk), .result_valid(result_valid), .mode_wr_valid(mode_wr_valid),
    .mode_wr_data(mode_wr_data), .op_valid(op_valid), .op_high(op_high),
    .op_low(op_low)
  );
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Idle outputs while reset is held
  task automatic idle_check();
    check(result_half, 16'h0000, "reset half");
    check({12'h000, flags}, 16'h0000, "reset flags");
    check({14'h0000, busy, result_valid}, 16'h0000, "reset strobes");
  endtask : idle_check
  // Cut a hang short
  initial begin
    #(40 * 3000);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    idle_check();
    #1 rst_b = 1'b1;
    for (int i = 0; i < NROW; i++) begin
      core.mode_write(rows[i].mode);
      core.op_start(rows[i].hi, rows[i].lo);
      if (rows[i].lat > 1) check({15'h0000, busy}, 16'h0001, "busy");
      core.op_wait(lat);
      check(result_half, rows[i].half, "half");
      check(16'(lat), 16'(rows[i].lat), "latency");
      check({15'h0000, flags[FLAG_V]}, {15'h0000, rows[i].v}, "overflow");
      @(posedge clk);
      #1 check({15'h0000, result_valid}, 16'h0000, "pulse");
    end
    // Mode write and second operate refused while dividing
    core.mode_write(7'h02);
    core.op_start(16'h0000, 16'h0064);
    core.mode_write(7'h08);
    core.op_start(16'h0000, 16'h0007);
    core.mode_write(7'h13);
    core.op_start(16'h0000, 16'h0003);
    core.op_wait(lat);
    check(result_half, 16'h000e, "busy refusal");
    core.mode_write(7'h23);
    check(result_half, 16'h0002, "remainder");
    // Mode write wins over a same-cycle operate
    core.mode_write(7'h04);
    fork
      core.mode_write(7'h03);
      core.op_start(16'h0003, 16'h0003);
    join
    repeat (3) @(posedge clk);
    #1 check(result_half, 16'h000e, "collision");
    // Reset in mid-run clears register one, read through its high half
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    idle_check();
    #1 rst_b = 1'b1;
    core.mode_write(7'h33);
    @(posedge clk);
    #1 check(result_half, 16'h0000, "reset r1");
    end_of_test();
  end
endmodule : multiply_divide_coprocessor_tb
